// ===== src/sic_top.sv
// System id and control registers behind an AXI4-Lite slave
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
// How it works
// - Identity reads a fixed code, never reset.
// - Bits 15:12 give the silicon revision.
// - Bits 11:10 show strap pins; bit 10 picks the on polarity default.
// - Low bytes give chip revision and mask id.
// - On bit reads 1 when running; 0 powers off.
// - Once off, any power-on event restarts.
// - Request 1 pulses both resets low; 0 does nothing.
// - Reboot bit picks off or reboot on fault shutdown.
// - Supply fault has over-voltage only with inclusion 1.
// - Reference sleeps if enabled and the fsm asks.
// - Halt bit at 1 freezes the watchdog.
// - Memory-valid cleared at startup and memory reset; software sets.
// - In hibernate, mode input 1 keeps memory-valid through the reset pulse.
// - Configured flag is plain storage.
// - On pin held 10 s, or 5 s if selected, shuts down.
// - On input active high at polarity 0, low at 1.
// - Interrupt active low at polarity 0, high at 1.
// - Request, halt, debounce, on polarity need the key.
// - State reset restores on, request, inclusion, chip reset, polarities.
module sic_top
    import sic_pkg::*;
#(
    parameter logic [31:0] RST_BASE_CYC = 32'(SIC_RST_BASE_CYC),
    parameter logic [31:0] DEB_SHORT_CYC = 32'(SIC_DEB_SHORT_CYC),
    parameter logic [31:0] DEB_LONG_CYC = 32'(SIC_DEB_LONG_CYC),
    // Identity values below are arbitrary
    parameter logic [15:0] DEV_IDENT = 16'h5a17,
    parameter logic [3:0] SILICON_REV = 4'h1,
    parameter logic [7:0] CUST_REV = 8'h01,
    parameter logic [7:0] MASK_IDENT = 8'h01
) (
    // Clock and reset
    input logic clock,
    input logic rst_b,
    // AXI4-Lite write address and data
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [SIC_AXI_AW-1:0] s_axi_awaddr,
    input logic [2:0] s_axi_awprot,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    input logic [SIC_AXI_AW-1:0] s_axi_araddr,
    input logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Device pins and power events
    input logic [1:0] configPinState,
    input logic onPin,
    input logic wakeEvent,
    input logic faultShutdown,
    input logic underVoltFault,
    input logic overVoltFault,
    input logic irqRequest,
    input logic fsmSleepRequest,
    input logic hibernate,
    input logic memresetHibernateMode,
    // Outputs
    output logic processorResetOut_b,
    output logic memoryResetOut_b,
    output logic supplyFaultOut_b,
    output logic irqOut,
    output logic referenceSleep,
    output logic watchdogHalt,
    output logic chipResetEnable,
    output logic chipActive
);

    ////////////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [15:0] merge16(logic [15:0] oldv, logic [15:0] newv,
                                            logic [15:0] mask);
        merge16 = (newv & mask) | (oldv & ~mask);
    endfunction : merge16

    // Strap bit 0 set flips the default on-key polarity
    function automatic logic cfgOnPol(logic [1:0] cfg);
        cfgOnPol = SIC_DEF_ONPOL ^ cfg[0];
    endfunction : cfgOnPol

    ////////////////////////////////////////////////////////////////////////////////
    // Reset synchroniser

    logic rstMeta_q;
    logic rstSync_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic cfgDone_q;
    logic [1:0] cfgPins_q;
    sic_pwr_t pwr_q;
    sic_pwr_t pwr_d;
    logic onPrev_q;
    logic onActive;
    logic powerOnEvent;
    logic startup;
    logic shutdown;
    logic swOff;
    logic rstReq_q, reboot_q, ovInc_q, bgSleep_q, wdHalt_q, chipRstEn_q;
    logic memValid_q, setUp_q, debSel_q, onPol_q, irqPol_q;
    logic [1:0] pulseLen_q;
    logic unlocked_q;
    logic [15:0] sysRd;
    logic [15:0] laneMask;
    logic [15:0] effMask;
    logic [15:0] wrVal;
    logic sysWr;
    logic keyWr;
    logic rstReqWr;
    logic rstLoad;
    logic rstBusy;
    logic rstDone;
    logic debDone;
    logic resetOut_b_q;
    logic supplyFault_b_q;
    logic irqOut_q;
    logic refSleep_q;
    logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
    logic [5:0] awIdx_q;
    logic [15:0] wData_q;
    logic [1:0] wStrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic doWrite;
    logic [5:0] arIdx;
    logic [15:0] rdVal;
    logic rdHit;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration pins, caught once after reset release

    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            cfgDone_q <= 1'b0;
            cfgPins_q <= 2'h0;
        end else if (!cfgDone_q) begin
            cfgDone_q <= 1'b1;
            cfgPins_q <= configPinState;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power state

    assign onActive = onPol_q ? ~onPin : onPin;
    assign powerOnEvent = (onActive & ~onPrev_q) | wakeEvent;
    assign swOff = sysWr && effMask[SIC_SC_ON] && !wrVal[SIC_SC_ON];
    assign shutdown = (pwr_q == SIC_PS_ACTIVE) && (swOff || faultShutdown || debDone);

    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            SIC_PS_OFF: begin
                if (cfgDone_q && powerOnEvent) begin
                    pwr_d = SIC_PS_ACTIVE;
                end
            end
            SIC_PS_ACTIVE: begin
                if (shutdown) begin
                    // Only a fault reboots; a software or on-pin off stays off
                    if (faultShutdown && reboot_q && !swOff && !debDone) begin
                        pwr_d = SIC_PS_RESTART;
                    end else begin
                        pwr_d = SIC_PS_OFF;
                    end
                end
            end
            SIC_PS_RESTART: begin
                pwr_d = SIC_PS_ACTIVE;
            end
            default: begin
                pwr_d = SIC_PS_OFF;
            end
        endcase
    end

    assign startup = (pwr_q != SIC_PS_ACTIVE) && (pwr_d == SIC_PS_ACTIVE);

    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            pwr_q <= SIC_PS_OFF;
            onPrev_q <= 1'b1;
        end else begin
            pwr_q <= pwr_d;
            onPrev_q <= onActive;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Timers: reset pulse and on-pin debounce

    assign rstReqWr = sysWr && effMask[SIC_SC_RSTREQ] && wrVal[SIC_SC_RSTREQ];
    assign rstLoad = startup || (rstReqWr && (pwr_q == SIC_PS_ACTIVE) && !shutdown);

    sic_timer #(
        .W(32)
    ) u_rstTimer (
        .clock(clock),
        .rstSync_b(rstSync_q),
        .load(rstLoad),
        .loadVal(RST_BASE_CYC << pulseLen_q),
        .busy(rstBusy),
        .done(rstDone)
    );

    // The count restarts whenever the pin lets go, so bounces never add up
    sic_timer #(
        .W(32)
    ) u_debTimer (
        .clock(clock),
        .rstSync_b(rstSync_q),
        .load(!(onActive && (pwr_q == SIC_PS_ACTIVE))),
        .loadVal(debSel_q ? DEB_SHORT_CYC : DEB_LONG_CYC),
        .busy(),
        .done(debDone)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // System control fields

    assign sysRd = {(pwr_q == SIC_PS_ACTIVE), rstReq_q, reboot_q, ovInc_q, pulseLen_q,
                    bgSleep_q, 1'b0, wdHalt_q, chipRstEn_q, memValid_q, setUp_q, debSel_q,
                    1'b0, onPol_q, irqPol_q};
    assign laneMask = {{8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
    assign effMask = laneMask & SIC_SC_WR_MASK
                   & (unlocked_q ? 16'hffff : ~SIC_SC_KEY_PROT);
    assign wrVal = merge16(sysRd, wData_q, effMask);
    assign sysWr = doWrite && (awIdx_q == SIC_IDX_SYSCTL1);
    assign keyWr = doWrite && (awIdx_q == SIC_IDX_KEY);

    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            reboot_q <= 1'b0;
            ovInc_q <= SIC_DEF_OVINC;
            pulseLen_q <= SIC_DEF_PULSE;
            bgSleep_q <= 1'b0;
            wdHalt_q <= 1'b0;
            chipRstEn_q <= 1'b0;
            setUp_q <= 1'b0;
            debSel_q <= 1'b0;
            onPol_q <= SIC_DEF_ONPOL;
            irqPol_q <= SIC_DEF_IRQPOL;
        end else begin
            if (sysWr) begin
                reboot_q <= wrVal[SIC_SC_REBOOT];
                ovInc_q <= wrVal[SIC_SC_OVINC];
                pulseLen_q <= wrVal[SIC_SC_PULSE+:2];
                bgSleep_q <= wrVal[SIC_SC_BGSLEEP];
                wdHalt_q <= wrVal[SIC_SC_WDHALT];
                chipRstEn_q <= wrVal[SIC_SC_CRSTEN];
                setUp_q <= wrVal[SIC_SC_SETUP];
                debSel_q <= wrVal[SIC_SC_DEB];
                onPol_q <= wrVal[SIC_SC_ONPOL];
                irqPol_q <= wrVal[SIC_SC_IRQPOL];
            end
            if (shutdown) begin
                ovInc_q <= SIC_DEF_OVINC;
                chipRstEn_q <= 1'b0;
                onPol_q <= cfgOnPol(cfgPins_q);
                irqPol_q <= SIC_DEF_IRQPOL;
            end
            if (!cfgDone_q) begin
                onPol_q <= cfgOnPol(configPinState);
            end
        end
    end

    // Request bit reads 1 for as long as the requested pulse runs
    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            rstReq_q <= 1'b0;
        end else if (shutdown) begin
            rstReq_q <= 1'b0;
        end else if (rstReqWr && (pwr_q == SIC_PS_ACTIVE)) begin
            rstReq_q <= 1'b1;
        end else if (rstDone) begin
            rstReq_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            memValid_q <= 1'b0;
        end else if (startup || (rstBusy && !(hibernate && memresetHibernateMode))) begin
            memValid_q <= 1'b0;
        end else if (sysWr && effMask[SIC_SC_MEMVALID]) begin
            memValid_q <= wrVal[SIC_SC_MEMVALID];
        end
    end

    // Any write to the key register other than the key locks again
    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            unlocked_q <= 1'b0;
        end else if (keyWr) begin
            unlocked_q <= (merge16(16'h0000, wData_q, laneMask) == SIC_UNLOCK_KEY);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin outputs

    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            resetOut_b_q <= 1'b0;
            supplyFault_b_q <= 1'b1;
            irqOut_q <= 1'b1;
            refSleep_q <= 1'b0;
        end else begin
            resetOut_b_q <= (pwr_q == SIC_PS_ACTIVE) && !rstBusy && !rstLoad;
            supplyFault_b_q <= !(underVoltFault || (overVoltFault && ovInc_q));
            irqOut_q <= irqPol_q ? irqRequest : !irqRequest;
            refSleep_q <= bgSleep_q && fsmSleepRequest;
        end
    end

    assign processorResetOut_b = resetOut_b_q;
    assign memoryResetOut_b = resetOut_b_q;
    assign supplyFaultOut_b = supplyFault_b_q;
    assign irqOut = irqOut_q;
    assign referenceSleep = refSleep_q;
    assign watchdogHalt = wdHalt_q;
    assign chipResetEnable = chipRstEn_q;
    assign chipActive = (pwr_q == SIC_PS_ACTIVE);

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    assign s_axi_awready = !awHeld_q && !bvalid_q;
    assign s_axi_wready = !wHeld_q && !bvalid_q;
    assign doWrite = awHeld_q && wHeld_q && !bvalid_q;

    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            bvalid_q <= 1'b0;
            awIdx_q <= 6'h00;
            wData_q <= 16'h0000;
            wStrb_q <= 2'h0;
            bresp_q <= SIC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awIdx_q <= s_axi_awaddr[SIC_AXI_AW-1:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata[15:0];
                wStrb_q <= s_axi_wstrb[1:0];
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                bvalid_q <= 1'b1;
                // Read-only registers drop writes; beyond the map is an error
                bresp_q <= (awIdx_q <= SIC_IDX_KEY) ? SIC_RESP_OKAY : SIC_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    assign arIdx = s_axi_araddr[SIC_AXI_AW-1:2];

    always_comb begin
        rdHit = 1'b1;
        if (arIdx == SIC_IDX_IDENT) begin
            rdVal = DEV_IDENT;
        end else if (arIdx == SIC_IDX_REVCFG) begin
            rdVal = {SILICON_REV, cfgPins_q, 2'h0, CUST_REV};
        end else if (arIdx == SIC_IDX_MASKREV) begin
            rdVal = {8'h00, MASK_IDENT};
        end else if (arIdx == SIC_IDX_SYSCTL1) begin
            rdVal = sysRd;
        end else if (arIdx == SIC_IDX_KEY) begin
            rdVal = {15'h0000, unlocked_q};
        end else begin
            rdVal = 16'h0000;
            rdHit = 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= SIC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0000, rdVal};
            rresp_q <= rdHit ? SIC_RESP_OKAY : SIC_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

endmodule : sic_top

// ===== src/sic_pkg.sv
// Constants and types of the system id and control block
package sic_pkg;

    // Clock and timing
    localparam int unsigned SIC_CLK_HZ = 200_000_000;
    localparam int unsigned SIC_RST_BASE_MS = 15;
    localparam int unsigned SIC_DEB_SHORT_S = 5;
    localparam int unsigned SIC_DEB_LONG_S = 10;
    localparam longint unsigned SIC_RST_BASE_CYC =
        longint'(SIC_RST_BASE_MS) * SIC_CLK_HZ / 1000;
    localparam longint unsigned SIC_DEB_SHORT_CYC = longint'(SIC_DEB_SHORT_S) * SIC_CLK_HZ;
    localparam longint unsigned SIC_DEB_LONG_CYC = longint'(SIC_DEB_LONG_S) * SIC_CLK_HZ;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices, byte address is four times the index
    localparam int SIC_AXI_AW = 8;
    localparam logic [5:0] SIC_IDX_IDENT = 6'h00;
    localparam logic [5:0] SIC_IDX_REVCFG = 6'h01;
    localparam logic [5:0] SIC_IDX_MASKREV = 6'h02;
    localparam logic [5:0] SIC_IDX_SYSCTL1 = 6'h03;
    localparam logic [5:0] SIC_IDX_KEY = 6'h04;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions of system_control_one
    localparam int SIC_SC_ON = 15;
    localparam int SIC_SC_RSTREQ = 14;
    localparam int SIC_SC_REBOOT = 13;
    localparam int SIC_SC_OVINC = 12;
    localparam int SIC_SC_PULSE = 10;
    localparam int SIC_SC_BGSLEEP = 9;
    localparam int SIC_SC_WDHALT = 7;
    localparam int SIC_SC_CRSTEN = 6;
    localparam int SIC_SC_MEMVALID = 5;
    localparam int SIC_SC_SETUP = 4;
    localparam int SIC_SC_DEB = 3;
    localparam int SIC_SC_ONPOL = 1;
    localparam int SIC_SC_IRQPOL = 0;
    localparam logic [15:0] SIC_SC_WR_MASK = 16'hfefb;
    localparam logic [15:0] SIC_SC_KEY_PROT = 16'h408a;

    // Field positions of revision_and_config
    localparam int SIC_RV_REV = 12;
    localparam int SIC_RV_CFG = 10;

    // Values after reset, and the unlock key
    localparam logic [1:0] SIC_DEF_PULSE = 2'h3;
    localparam logic SIC_DEF_OVINC = 1'b1;
    localparam logic SIC_DEF_ONPOL = 1'b1;
    localparam logic SIC_DEF_IRQPOL = 1'b0;
    localparam logic [15:0] SIC_UNLOCK_KEY = 16'h00ca;

    // Bus responses
    localparam logic [1:0] SIC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SIC_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SIC_PS_OFF = 3'b001,
        SIC_PS_ACTIVE = 3'b010,
        SIC_PS_RESTART = 3'b100
    } sic_pwr_t;

endpackage : sic_pkg

// ===== src/sic_timer.sv
// Loadable down counter for reset pulse and debounce
`timescale 1ns/10ps
module sic_timer #(
    parameter int W = 32
) (
    // Clock and reset
    input logic clock,
    input logic rstSync_b,
    // Control
    input logic load,
    input logic [W-1:0] loadVal,
    // Status
    output logic busy,
    output logic done
);

    logic [W-1:0] cnt_q;
    logic done_q;

    always_ff @(posedge clock or negedge rstSync_b) begin
        if (!rstSync_b) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= !load && (cnt_q == W'(1));
            if (load) begin
                cnt_q <= loadVal;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - W'(1);
            end
        end
    end

    assign busy = (cnt_q != '0);
    assign done = done_q;

endmodule : sic_timer

// ===== sim/sic_top_sva.sv
// Port assertions for the system id and control block
`timescale 1ns/10ps
module sic_top_sva
    import sic_pkg::*;
#(
    parameter logic [31:0] RST_BASE_CYC = 32'd20,
    parameter logic [15:0] DEV_IDENT = 16'h0
) (
    // Clock and reset
    input logic clock,
    input logic rst_b,
    // Read channel
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [SIC_AXI_AW-1:0] s_axi_araddr,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    // Device pins
    input logic underVoltFault,
    input logic fsmSleepRequest,
    input logic faultShutdown,
    input logic processorResetOut_b,
    input logic memoryResetOut_b,
    input logic supplyFaultOut_b,
    input logic referenceSleep,
    input logic chipActive
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    ////////////////////////////////
    // Cycles the reset output has been low
    logic [31:0] lowCnt_q;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lowCnt_q <= 32'h0;
        end else begin
            lowCnt_q <= processorResetOut_b ? 32'h0 : lowCnt_q + 32'h1;
        end
    end
    sequence arTake_s(logic [7:0] a);
        s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
    endsequence
    sequence wake_s;
        $rose(chipActive);
    endsequence
    ident_read_a: assert property (arTake_s(8'h00) |=> s_axi_rdata == {16'h0, DEV_IDENT})
        else $error("bad identity read");
    unmapped_read_a: assert property (arTake_s(8'h14) |=>
        s_axi_rresp == SIC_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("bad unmapped read");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    pulse_start_a: assert property (wake_s |-> ##[0:2] !processorResetOut_b)
        else $error("no reset pulse on wake");
    pulse_len_a: assert property ($rose(processorResetOut_b) && chipActive |-> lowCnt_q >= RST_BASE_CYC)
        else $error("reset pulse too short");
    reset_pair_a: assert property (memoryResetOut_b == processorResetOut_b)
        else $error("reset outputs differ");
    undervolt_a: assert property (underVoltFault |=> !supplyFaultOut_b)
        else $error("supply fault missing");
    sleep_gate_a: assert property (!fsmSleepRequest |=> !referenceSleep)
        else $error("reference slept unasked");
    fault_off_a: assert property (faultShutdown && chipActive |-> ##[1:2] !chipActive)
        else $error("fault did not shut down");
endmodule : sic_top_sva

// ===== sim/sic_host_model.sv
// Register bus host that drives the AXI4-Lite slave of the block
`timescale 1ns/10ps
module sic_host_model
    import sic_pkg::*;
(
    // Clock
    input logic clock,
    // Write channels
    output logic s_axi_awvalid = 1'b0,
    input logic s_axi_awready,
    output logic [SIC_AXI_AW-1:0] s_axi_awaddr = 8'h0,
    output logic [2:0] s_axi_awprot = 3'h0,
    output logic s_axi_wvalid = 1'b0,
    input logic s_axi_wready,
    output logic [31:0] s_axi_wdata = 32'h0,
    output logic [3:0] s_axi_wstrb = 4'h3,
    input logic s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    input logic [1:0] s_axi_bresp,
    // Read channels
    output logic s_axi_arvalid = 1'b0,
    input logic s_axi_arready,
    output logic [SIC_AXI_AW-1:0] s_axi_araddr = 8'h0,
    output logic [2:0] s_axi_arprot = 3'h0,
    input logic s_axi_rvalid,
    output logic s_axi_rready = 1'b0
);
    ////////////////////////////////
    // Released payloads invert so stale data is never mistaken
    task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~s_axi_awaddr;
            end
            if (s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~s_axi_araddr;
            end
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : sic_host_model

// ===== sim/tb.sv
// Self-checking bench for the system id and control block
`timescale 1ns/10ps
module tb;
    import sic_pkg::*;
    localparam logic [31:0] BASE = 32'd20;
    localparam logic [15:0] IDENT = 16'h3c5e; // Arbitrary identity value
    logic clock, rst_b, onPin, wakeEvent, faultShutdown, underVoltFault, overVoltFault;
    logic irqRequest, fsmSleepRequest, hibernate, memresetHibernateMode, onp;
    logic processorResetOut_b, memoryResetOut_b, supplyFaultOut_b, irqOut;
    logic referenceSleep, watchdogHalt, chipResetEnable, chipActive;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, configPinState, r;
    logic [15:0] wv;
    logic [33:0] expQ[$];
    int n_fail = 0;
    int checked = 0;
    int seed = 82012;
    int cnt;
    sic_top #(.RST_BASE_CYC(BASE), .DEB_SHORT_CYC(32'd50), .DEB_LONG_CYC(32'd100),
        .DEV_IDENT(IDENT)) u_dut (.*);
    sic_host_model u_host (.*);
    ////////////////////////////////
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e);
        expQ.push_back({e, 16'h0, d});
        u_host.rd(a);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] e);
        u_host.wr(a, d, r);
        check(r, e);
    endtask : wr
    // Read results are matched in issue order
    always @(posedge clock) begin
        if (s_axi_rvalid && s_axi_rready) begin
            check({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
        end
    end
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        configPinState = 2'($random(seed));
        irqRequest = 1'($random(seed));
        onp = ~configPinState[0];
        {rst_b, wakeEvent, faultShutdown, underVoltFault, overVoltFault} = 5'h0;
        {fsmSleepRequest, hibernate, memresetHibernateMode} = 3'h0;
        // Inactive on-pin level equals the polarity bit
        onPin = onp;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        check(irqOut, !irqRequest);
        rd(8'h00, IDENT, SIC_RESP_OKAY);
        rd(8'h04, {4'h1, configPinState, 2'h0, 8'h01}, SIC_RESP_OKAY);
        rd(8'h08, 16'h0001, SIC_RESP_OKAY);
        rd(8'h0c, {14'h0700, onp, 1'b0}, SIC_RESP_OKAY);
        rd(8'h14, 16'h0, SIC_RESP_SLVERR);
        wr(8'h14, 16'hffff, SIC_RESP_SLVERR);
        wakeEvent <= 1'b1;
        @(posedge clock);
        wakeEvent <= 1'b0;
        repeat (200) @(posedge clock);
        check(chipActive, 1'b1);
        wr(8'h0c, 16'h8080, SIC_RESP_OKAY);
        rd(8'h0c, {14'h2000, onp, 1'b0}, SIC_RESP_OKAY);
        wr(8'h10, SIC_UNLOCK_KEY, SIC_RESP_OKAY);
        wv = 16'hb3fd | {onp, 1'b0};
        fsmSleepRequest <= 1'b1;
        overVoltFault <= 1'b1;
        wr(8'h0c, wv, SIC_RESP_OKAY);
        rd(8'h0c, wv & 16'hfefb, SIC_RESP_OKAY);
        check({watchdogHalt, chipResetEnable, irqOut, referenceSleep, supplyFaultOut_b},
            {2'h3, irqRequest, 2'h2});
        underVoltFault <= 1'b1;
        repeat (2) @(posedge clock);
        check(supplyFaultOut_b, 1'b0);
        underVoltFault <= 1'b0;
        wr(8'h0c, wv | 16'h4000, SIC_RESP_OKAY);
        @(posedge clock);
        for (cnt = 0; cnt < 99 && !processorResetOut_b; cnt++) @(posedge clock);
        check(cnt >= BASE - 2 && cnt <= BASE + 1, 1'b1);
        rd(8'h0c, wv & 16'hfedb, SIC_RESP_OKAY);
        faultShutdown <= 1'b1;
        @(posedge clock);
        faultShutdown <= 1'b0;
        repeat (60) @(posedge clock);
        check(chipActive, 1'b1);
        check(irqOut, !irqRequest);
        rd(8'h0c, 16'hb298 | {onp, 1'b0}, SIC_RESP_OKAY);
        // Short debounce: off after 50 held cycles
        onPin <= ~onp;
        repeat (40) @(posedge clock);
        check(chipActive, 1'b1);
        repeat (20) @(posedge clock);
        check(chipActive, 1'b0);
        onPin <= onp;
        @(posedge clock);
        onPin <= ~onp;
        repeat (4) @(posedge clock);
        check(chipActive, 1'b1);
        onPin <= onp;
        wr(8'h0c, 16'h0018 | {onp, 1'b0}, SIC_RESP_OKAY);
        rd(8'h0c, 16'h1018 | {onp, 1'b0}, SIC_RESP_OKAY);
        check(chipActive, 1'b0);
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        rd(8'h00, IDENT, SIC_RESP_OKAY);
        rd(8'h0c, {14'h0700, onp, 1'b0}, SIC_RESP_OKAY);
        repeat (4) @(posedge clock);
        tally_and_finish();
    end
endmodule : tb
bind sic_top sic_top_sva #(.RST_BASE_CYC(RST_BASE_CYC), .DEV_IDENT(DEV_IDENT)) u_sva (.*);
